// ---- hw/fcs_defines.vh ----
// Constants for the fail-safe clock switch and monitor block.
// Assumes a single 10 MHz core clock and a register port with one-cycle read latency.
// Operation
// - With monitor enabled, keep slow RC running always except in Sleep, ignoring watchdog enable.
// - On active oscillator failure raise clock-fail trap and move system clock to fast RC.
// - Clock failure leaves watchdog untouched; watchdog keeps running on slow RC clock.
// - Power-up timer expiring before oscillator starts raises trap and selects fast RC.
// - On failure load bits 14:12 with fast RC, set bit 3, clear bit 0.
// - Switch only among four groups; primary option comes from five-bit configuration field. The code accepts any three-bit value in bits 10:8 as the new group.
// - Current-source field is read-only and shows the group now in effect.
// - Power-on and brown-out reset load both source fields from source-select configuration.
// - A status bit reports PLL lock.
// - Clock-fail flag is read-only and shows a failure was detected.
// - Switch-enable bit rises when a switch starts; software clearing it aborts the switch.
// - Switch-and-monitor configuration 1x disables both switching and the monitor.
// - With switching disabled configuration selects oscillator; current field only reflects it.
// - Slow RC reference clock runs at nominal 512 kHz.
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

`define FCS_ADDR_CTRL      4'h0
`define FCS_ADDR_IRQ_STAT  4'h1
`define FCS_ADDR_IRQ_MASK  4'h2

`define FCS_CURRENT_SOURCE_FIELD_HI        14
`define FCS_CURRENT_SOURCE_FIELD_LO        12
`define FCS_NEW_SOURCE_FIELD_HI        10
`define FCS_NEW_SOURCE_FIELD_LO        8
`define FCS_LOCK_BIT       5
`define FCS_CF_BIT         3
`define FCS_SWITCH_ENABLE_BIT_BIT      0

`define FCS_GRP_SECONDARY  3'h0
`define FCS_GRP_FAST_RC    3'h1
`define FCS_GRP_SLOW_RC    3'h2
`define FCS_GRP_PRIMARY    3'h3

`define FCS_IRQ_FAIL       0
`define FCS_IRQ_SWITCH     1
`define FCS_IRQ_ABORT      2

`define FCS_SLOW_RC_KHZ    512
`define FCS_CORE_KHZ       10000
`define FCS_FAIL_PERIODS   4
`define FCS_SWITCH_WAIT    8
`define FCS_POWER_UP_TIMER_US        64

`endif

// ---- hw/fcs_edge_watch.v ----
// Watchdog on a supervised clock seen as a sampled level in the core domain.
// Assumes the clock input is already synchronised; reference ticks are one-cycle pulses.
`timescale 1ns/10ps
module fcs_edge_watch #(
    parameter LIMIT = 4
) (
    core_clk,
    arst_n,
    enable,
    clk_level,
    ref_tick,
    fail
);
    input  wire       core_clk;
    input  wire       arst_n;
    input  wire       enable;
    input  wire       clk_level;
    input  wire       ref_tick;
    output reg        fail;

    reg                last_reg;
    reg  [7:0]         cnt_reg;
    wire               edge_seen;

    assign edge_seen = clk_level ^ last_reg;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_reg <= 1'b0;
            cnt_reg  <= 8'h00;
            fail     <= 1'b0;
        end else begin
            last_reg <= clk_level;
            fail     <= 1'b0;
            if (!enable || edge_seen) begin
                cnt_reg <= 8'h00;
            end else if (ref_tick) begin
                // A clock that stays still for LIMIT reference periods is dead.
                if (cnt_reg == LIMIT[7:0] - 8'h01) begin
                    fail    <= 1'b1;
                    cnt_reg <= 8'h00;
                end else begin
                    cnt_reg <= cnt_reg + 8'h01;
                end
            end
        end
    end
endmodule // fcs_edge_watch

// ---- hw/fcs_clock_switch.v ----
// Clock source switch controller with fail-safe monitor and control register.
// Assumes slow_rc_tick is a core-domain pulse per slow RC period and the oscillator
// clock and ready inputs arrive asynchronously.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "fcs_defines.vh"
module fcs_clock_switch #(
    parameter FAIL_PERIODS = `FCS_FAIL_PERIODS,
    parameter SWITCH_WAIT  = `FCS_SWITCH_WAIT
) (
    core_clk,
    arst_n,
    por_bor,
    sleep_mode,
    soft_watchdog_enable,
    switch_monitor_cfg,
    source_select_cfg,
    primary_option_cfg,
    sys_clk_sample,
    osc_ready,
    pll_lock,
    power_up_timer_expired,
    slow_rc_tick,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata,
    osc_group_sel,
    osc_option_sel,
    slow_rc_osc_en,
    watchdog_tick,
    clock_fail_trap,
    irq
);
    input  wire        core_clk;
    input  wire        arst_n;
    input  wire        por_bor;
    input  wire        sleep_mode;
    input  wire        soft_watchdog_enable;
    input  wire [1:0]  switch_monitor_cfg;
    input  wire [2:0]  source_select_cfg;
    input  wire [4:0]  primary_option_cfg;
    input  wire        sys_clk_sample;
    input  wire        osc_ready;
    input  wire        pll_lock;
    input  wire        power_up_timer_expired;
    input  wire        slow_rc_tick;
    input  wire [3:0]  reg_addr;
    input  wire [15:0] reg_wdata;
    input  wire        reg_wr;
    input  wire        reg_rd;
    output reg  [15:0] reg_rdata;
    output reg  [2:0]  osc_group_sel;
    output reg  [4:0]  osc_option_sel;
    output reg         slow_rc_osc_en;
    output reg         watchdog_tick;
    output reg         clock_fail_trap;
    output reg         irq;

    localparam ST_IDLE   = 2'b00;
    localparam ST_SWITCH = 2'b01;

    reg  [1:0]  clk_sync_reg;
    reg  [1:0]  rdy_sync_reg;
    reg  [1:0]  lock_sync_reg;
    reg  [1:0]  power_up_timer_sync_reg;
    reg         power_up_timer_seen_reg;
    reg         cfg_loaded_reg;
    reg  [1:0]  state_reg;
    reg  [7:0]  wait_reg;
    reg  [2:0]  current_source_field_reg;
    reg  [2:0]  new_source_field_reg;
    reg         cf_reg;
    reg         switch_enable_bit_reg;
    reg  [2:0]  irq_stat_reg;
    reg  [2:0]  irq_mask_reg;
    reg  [2:0]  ev_next;
    wire        mon_en;
    wire        sw_en;
    wire        watch_fail;
    wire        power_up_timer_rise;
    wire        start_fail;
    wire        fail_event;
    wire [15:0] ctrl_word;

    // Configuration 1x shuts both the switch logic and the monitor off.
    assign sw_en  = ~switch_monitor_cfg[1];
    assign mon_en = sw_en & ~switch_monitor_cfg[0];

    function [15:0] pack_ctrl;
        input [2:0] cur;
        input [2:0] nxt;
        input       lock;
        input       cf;
        input       en;
        begin
            pack_ctrl = 16'h0000;
            pack_ctrl[`FCS_CURRENT_SOURCE_FIELD_HI:`FCS_CURRENT_SOURCE_FIELD_LO] = cur;
            pack_ctrl[`FCS_NEW_SOURCE_FIELD_HI:`FCS_NEW_SOURCE_FIELD_LO] = nxt;
            pack_ctrl[`FCS_LOCK_BIT]             = lock;
            pack_ctrl[`FCS_CF_BIT]               = cf;
            pack_ctrl[`FCS_SWITCH_ENABLE_BIT_BIT]            = en;
        end
    endfunction

    assign ctrl_word = pack_ctrl(current_source_field_reg, new_source_field_reg, lock_sync_reg[1], cf_reg, switch_enable_bit_reg);

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            clk_sync_reg  <= 2'b00;
            rdy_sync_reg  <= 2'b00;
            lock_sync_reg <= 2'b00;
            power_up_timer_sync_reg <= 2'b00;
        end else begin
            clk_sync_reg  <= {clk_sync_reg[0], sys_clk_sample};
            rdy_sync_reg  <= {rdy_sync_reg[0], osc_ready};
            lock_sync_reg <= {lock_sync_reg[0], pll_lock};
            power_up_timer_sync_reg <= {power_up_timer_sync_reg[0], power_up_timer_expired};
        end
    end

    fcs_edge_watch #(
        .LIMIT (FAIL_PERIODS)
    ) u_watch (
        .core_clk  (core_clk),
        .arst_n    (arst_n),
        .enable    (mon_en & power_up_timer_seen_reg & ~sleep_mode & current_source_field_reg != `FCS_GRP_FAST_RC),
        .clk_level (clk_sync_reg[1]),
        .ref_tick  (slow_rc_tick),
        .fail      (watch_fail)
    );

    assign power_up_timer_rise  = power_up_timer_sync_reg[1] & ~power_up_timer_seen_reg;
    // Timer ran out while the chosen oscillator still had not started.
    assign start_fail = mon_en & power_up_timer_rise & ~rdy_sync_reg[1] & current_source_field_reg != `FCS_GRP_FAST_RC;
    assign fail_event = watch_fail | start_fail;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            power_up_timer_seen_reg   <= 1'b0;
            cfg_loaded_reg  <= 1'b0;
            state_reg       <= ST_IDLE;
            wait_reg        <= 8'h00;
            current_source_field_reg        <= `FCS_GRP_FAST_RC;
            new_source_field_reg        <= `FCS_GRP_FAST_RC;
            cf_reg          <= 1'b0;
            switch_enable_bit_reg       <= 1'b0;
            clock_fail_trap <= 1'b0;
            irq_stat_reg    <= 3'h0;
            irq_mask_reg    <= 3'h0;
            ev_next         <= 3'h0;
        end else begin
            ev_next         <= 3'h0;
            clock_fail_trap <= 1'b0;
            if (por_bor) begin
                power_up_timer_seen_reg  <= 1'b0;
                cfg_loaded_reg <= 1'b0;
                cf_reg         <= 1'b0;
                switch_enable_bit_reg      <= 1'b0;
                state_reg      <= ST_IDLE;
            end else if (!cfg_loaded_reg) begin
                cfg_loaded_reg <= 1'b1;
                current_source_field_reg       <= source_select_cfg;
                new_source_field_reg       <= source_select_cfg;
            end else begin
                if (power_up_timer_sync_reg[1]) begin
                    power_up_timer_seen_reg <= 1'b1;
                end
                if (reg_wr && reg_addr == `FCS_ADDR_CTRL && sw_en) begin
                    new_source_field_reg <= reg_wdata[`FCS_NEW_SOURCE_FIELD_HI:`FCS_NEW_SOURCE_FIELD_LO];
                end
                if (!sw_en) begin
                    current_source_field_reg  <= source_select_cfg;
                    switch_enable_bit_reg <= 1'b0;
                    state_reg <= ST_IDLE;
                end else if (fail_event) begin
                    // Fast RC code, the flag and the abandoned switch all take effect on the same edge.
                    current_source_field_reg        <= `FCS_GRP_FAST_RC;
                    cf_reg          <= 1'b1;
                    switch_enable_bit_reg       <= 1'b0;
                    state_reg       <= ST_IDLE;
                    clock_fail_trap <= 1'b1;
                    ev_next[`FCS_IRQ_FAIL] <= 1'b1;
                end else begin
                    case (state_reg)
                    ST_IDLE: begin
                        if (reg_wr && reg_addr == `FCS_ADDR_CTRL && reg_wdata[`FCS_SWITCH_ENABLE_BIT_BIT]) begin
                            switch_enable_bit_reg <= 1'b1;
                            // Only the group changes; within-group choice stays with configuration.
                            if (reg_wdata[`FCS_NEW_SOURCE_FIELD_HI:`FCS_NEW_SOURCE_FIELD_LO] != current_source_field_reg) begin
                                state_reg <= ST_SWITCH;
                                wait_reg  <= 8'h00;
                            end else begin
                                switch_enable_bit_reg <= 1'b0;
                            end
                        end
                    end
                    ST_SWITCH: begin
                        if (reg_wr && reg_addr == `FCS_ADDR_CTRL && !reg_wdata[`FCS_SWITCH_ENABLE_BIT_BIT]) begin
                            switch_enable_bit_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                            ev_next[`FCS_IRQ_ABORT] <= 1'b1;
                        end else if (wait_reg >= SWITCH_WAIT[7:0]) begin
                            current_source_field_reg  <= new_source_field_reg;
                            switch_enable_bit_reg <= 1'b0;
                            state_reg <= ST_IDLE;
                            ev_next[`FCS_IRQ_SWITCH] <= 1'b1;
                        end else if (slow_rc_tick) begin
                            wait_reg <= wait_reg + 8'h01;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                    endcase
                end
            end
            if (reg_wr && reg_addr == `FCS_ADDR_IRQ_MASK) begin
                irq_mask_reg <= reg_wdata[2:0];
            end
            // A new event wins over a write-one clear in the same cycle.
            irq_stat_reg <= (irq_stat_reg & ~((reg_wr && reg_addr == `FCS_ADDR_IRQ_STAT) ?
                            reg_wdata[2:0] : 3'h0)) | ev_next;
        end
    end

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata      <= 16'h0000;
            osc_group_sel  <= `FCS_GRP_FAST_RC;
            osc_option_sel <= 5'h00;
            slow_rc_osc_en <= 1'b1;
            watchdog_tick  <= 1'b0;
            irq            <= 1'b0;
        end else begin
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                `FCS_ADDR_CTRL:     reg_rdata <= ctrl_word;
                `FCS_ADDR_IRQ_STAT: reg_rdata <= {13'h0000, irq_stat_reg};
                `FCS_ADDR_IRQ_MASK: reg_rdata <= {13'h0000, irq_mask_reg};
                default:            reg_rdata <= 16'h0000;
                endcase
            end
            osc_group_sel  <= sw_en ? current_source_field_reg : source_select_cfg;
            osc_option_sel <= primary_option_cfg;
            // The slow RC serves the power-up timer, so it runs until that expires.
            slow_rc_osc_en <= ~sleep_mode & (mon_en | ~power_up_timer_seen_reg | soft_watchdog_enable |
                              current_source_field_reg == `FCS_GRP_SLOW_RC);
            watchdog_tick  <= slow_rc_tick;
            irq            <= |(irq_stat_reg & irq_mask_reg);
        end
    end
endmodule // fcs_clock_switch

// ---- verif/fcs_osc_model.sv ----
// Far-side model: supervised clock, oscillator start, PLL lock, power-up timer, slow RC ticks.
// Assumes a 10 MHz core clock; the bench stops the clock or delays the start on purpose.
`timescale 1ns/10ps
module fcs_osc_model #(
    parameter TICK_DIV    = 20,
    parameter POWER_UP_TIMER_TICKS  = 4,
    parameter START_TICKS = 2
) (
    input wire   core_clk,
    input wire   arst_n,
    input wire   por_bor,
    input wire   stop_clk,
    input wire   late_start,
    output logic sys_clk_sample,
    output logic osc_ready,
    output logic pll_lock,
    output logic power_up_timer_expired,
    output logic slow_rc_tick
);
    int div_reg;
    int ticks_reg;
    // A dead oscillator holds its last level, which is what the monitor must catch.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg        <= 0;
            ticks_reg      <= 0;
            slow_rc_tick   <= 1'b0;
            sys_clk_sample <= 1'b0;
        end else begin
            slow_rc_tick <= (div_reg == TICK_DIV - 1);
            div_reg      <= (div_reg == TICK_DIV - 1) ? 0 : div_reg + 1;
            ticks_reg    <= por_bor ? 0 : ticks_reg + (slow_rc_tick && ticks_reg < 99);
            if (!stop_clk)
                sys_clk_sample <= ~sys_clk_sample;
        end
    end
    assign power_up_timer_expired = (ticks_reg >= POWER_UP_TIMER_TICKS);
    assign osc_ready    = !late_start && (ticks_reg >= START_TICKS);
    assign pll_lock     = osc_ready;
endmodule // fcs_osc_model

// ---- verif/fcs_clock_switch_monitor.sv ----
// Checker for the clock switch: trap, group, watchdog and read-port relations.
// Assumes it is bound to the switch top and sees only its ports.
`timescale 1ns/10ps
module fcs_switch_chk (
    input wire        core_clk,
    input wire        arst_n,
    input wire        sleep_mode,
    input wire [1:0]  switch_monitor_cfg,
    input wire [2:0]  source_select_cfg,
    input wire [4:0]  primary_option_cfg,
    input wire        slow_rc_tick,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    input wire [2:0]  osc_group_sel,
    input wire [4:0]  osc_option_sel,
    input wire        slow_rc_osc_en,
    input wire        watchdog_tick,
    input wire        clock_fail_trap
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    sequence s_fast_selected;
        ##1 osc_group_sel == 3'h1;
    endsequence
    sequence s_cfg_held;
        (switch_monitor_cfg[1] && $stable(source_select_cfg)) [*4];
    endsequence
    a_trap_one_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
        else $error("trap longer than one cycle");
    a_trap_to_fast: assert property (clock_fail_trap |-> s_fast_selected)
        else $error("trap without fast RC group");
    a_wdt_tick: assert property (slow_rc_tick |=> watchdog_tick)
        else $error("watchdog tick lost");
    a_wdt_quiet: assert property (!slow_rc_tick |=> !watchdog_tick)
        else $error("stray watchdog tick");
    a_slow_rc_on: assert property ((switch_monitor_cfg == 2'b00 && !sleep_mode) |=> slow_rc_osc_en)
        else $error("slow RC off while monitoring");
    a_option_copy: assert property (1'b1 |=> osc_option_sel == $past(primary_option_cfg))
        else $error("primary option not passed on");
    a_cfg_direct: assert property (s_cfg_held |-> osc_group_sel == source_select_cfg)
        else $error("group not taken from configuration");
    a_no_trap_off: assert property (switch_monitor_cfg[1] [*3] |-> !clock_fail_trap)
        else $error("trap while monitor disabled");
    a_trap_needs_mon: assert property (clock_fail_trap |-> $past(switch_monitor_cfg, 2) == 2'b00)
        else $error("trap without monitor enabled");
    a_read_idle: assert property (!reg_rd |=> reg_rdata == 16'h0)
        else $error("read data outside read slot");
endmodule // fcs_switch_chk
bind fcs_clock_switch fcs_switch_chk u_chk (.core_clk, .arst_n, .sleep_mode, .switch_monitor_cfg,
    .source_select_cfg, .primary_option_cfg, .slow_rc_tick, .reg_rd, .reg_rdata, .osc_group_sel,
    .osc_option_sel, .slow_rc_osc_en, .watchdog_tick, .clock_fail_trap);

// ---- verif/fcs_clock_switch_tb.sv ----
// Testbench for the clock switch: register access, switch, abort, failure and start traps.
// Assumes the oscillator model on the far side and the bound checker.
`timescale 1ns/10ps
module fcs_clock_switch_tb;
    logic        core_clk, arst_n, por_bor, stop_clk, late_start, reg_wr, reg_rd;
    logic [1:0]  cfg;
    logic [2:0]  src, osc_group_sel;
    logic [3:0]  reg_addr;
    logic [4:0]  osc_option_sel;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    logic        sys_clk_sample, osc_ready, pll_lock, power_up_timer_expired, slow_rc_tick;
    logic        slow_rc_osc_en, watchdog_tick, clock_fail_trap, irq;
    logic        sleep_mode, soft_wd;
    int          n_fail = 0, checks = 0, cnt, wcnt;
    fcs_clock_switch dut (.core_clk, .arst_n, .por_bor, .sleep_mode, .soft_watchdog_enable(soft_wd),
        .switch_monitor_cfg(cfg), .source_select_cfg(src), .primary_option_cfg(5'h0a), .sys_clk_sample,
        .osc_ready, .pll_lock, .power_up_timer_expired, .slow_rc_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .osc_group_sel, .osc_option_sel, .slow_rc_osc_en, .watchdog_tick, .clock_fail_trap, .irq);
    fcs_osc_model u_osc (.core_clk, .arst_n, .por_bor, .stop_clk, .late_start, .sys_clk_sample,
        .osc_ready, .pll_lock, .power_up_timer_expired, .slow_rc_tick);
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        rd_val = reg_rdata;
    endtask
    // Counts traps and watchdog ticks over a fixed window.
    task automatic watch(input int n);
        cnt  = 0;
        wcnt = 0;
        repeat (n) begin
            @(posedge core_clk);
            #1;
            cnt  += clock_fail_trap;
            wcnt += watchdog_tick;
        end
    endtask
    task automatic por_pulse();
        @(posedge core_clk);
        por_bor <= 1'b1;
        repeat (2) @(posedge core_clk);
        por_bor <= 1'b0;
    endtask
    task automatic t_reset();
        rd(4'h0);
        chk("ctrl reset", 16'h3320, rd_val);
        rd(4'hf);
        chk("unmapped", 16'h0000, rd_val);
        rd(4'h2);
        chk("mask reset", 16'h0000, rd_val);
        chk("rc on", 16'h0001, {15'h0, slow_rc_osc_en});
        @(posedge core_clk);
        sleep_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("rc sleep", 16'h0000, {15'h0, slow_rc_osc_en});
        @(posedge core_clk);
        sleep_mode <= 1'b0;
    endtask
    task automatic t_switch();
        wr(4'h2, 16'h0007);
        wr(4'h0, 16'h7201);
        rd(4'h0);
        chk("ctrl start", 16'h3221, rd_val);
        repeat (250) @(posedge core_clk);
        rd(4'h1);
        chk("switch status", 16'h0002, rd_val);
        chk("irq set", 16'h0001, {15'h0, irq});
        rd(4'h0);
        chk("ctrl done", 16'h2220, rd_val);
        wr(4'h1, 16'h0002);
        rd(4'h1);
        chk("status clear", 16'h0000, rd_val);
        chk("irq clear", 16'h0000, {15'h0, irq});
    endtask
    task automatic t_abort();
        wr(4'h0, 16'h0001);
        wr(4'h0, 16'h0000);
        repeat (250) @(posedge core_clk);
        rd(4'h1);
        chk("abort status", 16'h0004, rd_val);
        rd(4'h0);
        chk("ctrl kept", 16'h2020, rd_val);
        wr(4'h1, 16'h0004);
    endtask
    task automatic t_fail();
        stop_clk <= 1'b1;
        watch(300);
        chk("trap count", 16'h0001, cnt[15:0]);
        chk("wdt ticks", 16'h000f, wcnt[15:0]);
        wr(4'h0, 16'h0000);
        rd(4'h0);
        chk("ctrl fail", 16'h1008, rd_val & 16'h7009);
        rd(4'h1);
        chk("fail status", 16'h0001, rd_val);
        chk("irq fail", 16'h0001, {15'h0, irq});
        wr(4'h1, 16'h0001);
        stop_clk <= 1'b0;
    endtask
    task automatic t_start();
        late_start <= 1'b1;
        por_pulse();
        watch(300);
        chk("start trap", 16'h0001, cnt[15:0]);
        rd(4'h0);
        chk("ctrl start fail", 16'h1008, rd_val & 16'h7009);
        src        <= 3'h0;
        late_start <= 1'b0;
        por_pulse();
        repeat (150) @(posedge core_clk);
        rd(4'h0);
        chk("ctrl reload", 16'h0020, rd_val);
        wr(4'h1, 16'h0001);
    endtask
    task automatic t_off();
        cfg <= 2'b10;
        src <= 3'h3;
        wr(4'h0, 16'h0201);
        stop_clk <= 1'b1;
        watch(300);
        chk("trap when off", 16'h0000, cnt[15:0]);
        chk("group from cfg", 16'h0003, {13'h0, osc_group_sel});
        rd(4'h0);
        chk("ctrl reflects", 16'h3000, rd_val & 16'h7001);
        chk("rc off", 16'h0000, {15'h0, slow_rc_osc_en});
        @(posedge core_clk);
        soft_wd <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("rc wdt", 16'h0001, {15'h0, slow_rc_osc_en});
    endtask
    task automatic give_verdict();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        #2_000_000;
        n_fail++;
        give_verdict();
    end
    initial begin
        arst_n     = 1'b0;
        por_bor    = 1'b0;
        stop_clk   = 1'b0;
        late_start = 1'b0;
        sleep_mode = 1'b0;
        soft_wd    = 1'b0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_addr   = 4'h0;
        reg_wdata  = 16'h0;
        cfg        = 2'b00;
        src        = 3'h3;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (150) @(posedge core_clk);
        t_reset();
        t_switch();
        t_abort();
        t_fail();
        t_start();
        t_off();
        give_verdict();
    end
endmodule // fcs_clock_switch_tb
